// ### inc/scsc_cfg.svh
/*
  Register indices, field positions, reset values and frame timing of the
  smart card serial channel. Included by the channel top module.
*/
`ifndef SCSC_CFG_SVH
`define SCSC_CFG_SVH
// register indices; byte address is four times the index
`define SCSC_IDX_FRAME 3'h0
`define SCSC_IDX_RATE 3'h1
`define SCSC_IDX_CTRL 3'h2
`define SCSC_IDX_SBUF 3'h3
`define SCSC_IDX_FLAGS 3'h4
`define SCSC_IDX_RBUF 3'h5
`define SCSC_IDX_MODE 3'h6
// frame_cfg fields
`define SCSC_FC_GSM 7
`define SCSC_FC_ODD 4
`define SCSC_FC_PS 1:0
// serial_ctrl fields
`define SCSC_SC_SIRQ 7
`define SCSC_SC_RIRQ 6
`define SCSC_SC_SEND 5
`define SCSC_SC_RCV 4
`define SCSC_SC_FIX 1
`define SCSC_SC_CKO 0
// serial_flags fields
`define SCSC_FL_SBE 7
`define SCSC_FL_RBF 6
`define SCSC_FL_OVR 5
`define SCSC_FL_NACK 4
`define SCSC_FL_PAR 3
`define SCSC_FL_DONE 2
// card mode register fields
`define SCSC_MD_MSB 3
`define SCSC_MD_INV 2
`define SCSC_MD_ON 0
`define SCSC_MODE_MASK 8'h0d
`define SCSC_FLAGS_MASK 8'hfc
// reset values
`define SCSC_RST_FRAME 8'h00
`define SCSC_RST_RATE 8'hff
`define SCSC_RST_CTRL 8'h00
`define SCSC_RST_FLAGS 8'h84
`define SCSC_RST_MODE 8'h00
// base clock ticks per etu, and the last tick of a half etu
`define SCSC_ETU_BASE 372
`define SCSC_HALF_LAST 8'(`SCSC_ETU_BASE / 2 - 1)
// frame positions in half etu counted from the start edge
`define SCSC_H_PAR 5'd19
`define SCSC_H_PAR_END 5'd20
`define SCSC_H_ERR_ON 5'd21
`define SCSC_H_ERR_OFF 5'(`SCSC_H_ERR_ON + 5'd2)
`define SCSC_H_NACK 5'd22
`define SCSC_H_DONE_GSM 5'd22
`define SCSC_H_DONE 5'd25
`define SCSC_H_RESEND 5'd27
`endif

// ### inc/scsc_pkg.sv
/*
  Types of the smart card serial channel: state encodings.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package scsc_pkg;
  typedef enum logic [1:0] {SCSC_TX_IDLE, SCSC_TX_FRAME, SCSC_TX_GAP} scsc_tx_state_type;
  typedef enum logic {SCSC_RX_IDLE, SCSC_RX_FRAME} scsc_rx_state_type;
endpackage
`default_nettype wire

// ### inc/scsc_rate_if.sv
/*
  Interface between the channel top and its bit-rate generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface scsc_rate_if;
  logic ce;
  logic [1:0] psel;
  logic [7:0] div;
  logic half_tick;
  logic base_tick;
  modport gen (input ce, input psel, input div, output half_tick, output base_tick);
  modport user (output ce, output psel, output div, input half_tick, input base_tick);
endinterface
`default_nettype wire

// ### logic/scsc_rate_gen.sv
/*
  Bit-rate generator: prescaler of 2^(2n) clocks, then divisor+1, gives
  a half tick; every second half tick is one base tick (372 per etu).
  Assumes psel and div are stable register outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module scsc_rate_gen
  import scsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  scsc_rate_if.gen rate
);
  logic [5:0] pre_q;
  logic [5:0] pre_d;
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic phase_q;
  logic phase_d;
  logic half_q;
  logic half_d;
  logic base_q;
  logic base_d;
  logic [5:0] pre_last;

  // base clock = clk / (2^(2n+1) * (div+1)), bit rate = that / 372
  always_comb
  begin
    pre_last = 6'((7'h01 << {rate.psel, 1'b0}) - 7'h01);
    pre_d = pre_q;
    div_d = div_q;
    phase_d = phase_q;
    half_d = half_q;
    base_d = base_q;
    if (rate.ce)
    begin
      half_d = 1'b0;
      base_d = 1'b0;
      if (pre_q >= pre_last)
      begin
        pre_d = 6'h00;
        if (div_q >= rate.div)
        begin
          div_d = 8'h00;
          half_d = 1'b1;
          phase_d = ~phase_q;
          base_d = phase_q;
        end
        else
        begin
          div_d = div_q + 8'h01;
        end
      end
      else
      begin
        pre_d = pre_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_q <= 6'h00;
      div_q <= 8'h00;
      phase_q <= 1'b0;
      half_q <= 1'b0;
      base_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      div_q <= div_d;
      phase_q <= phase_d;
      half_q <= half_d;
      base_q <= base_d;
    end
  end

  assign rate.half_tick = half_q;
  assign rate.base_tick = base_q;
endmodule
`default_nettype wire

// ### logic/scsc_sync.sv
/*
  Two flip-flop synchroniser for the shared card data line.
  Assumes the input is asynchronous to clk_i; idle level is high.
*/
`timescale 1ns/1ps
`default_nettype none
module scsc_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // first stage feeds only the second
  always_comb
  begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else if (ce_i)
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// ### logic/scsc_top.sv
/*
  Smart card serial channel: Wishbone register file, half-duplex card
  frame transmitter with retransmission, receiver with error signal,
  card clock output and interrupt request levels.
  Assumes one clock, a pulled-up shared data line resolved outside.
*/
// The register addresses and the Wishbone slave port were chosen for this implementation.
// Overview of operation
// - bit rate is clock over 1488 times 2^(2n-1) times divisor plus one
// - prescaler zero and divisor zero give the highest card bit rate
// - card mode hands data pins to the channel, released to high impedance
// - clock-output-on drives the serial clock on the card clock pin
// - send_buf written and empty cleared starts a frame and clears send_done
// - send interrupt requested while send_done is set and its mask allows
// - fault interrupt from overrun, parity or nack flag, receive mask gated
// - receive interrupt from rcv_buf_full, gated by receive mask
// - no separate send-end interrupt; send_done feeds only the send interrupt
// - send_buf writes clear flags so DMA sends all bytes, retries unseen
// - error frames never set rcv_buf_full, so DMA skips them
// - parity fault frames still load rcv_buf for software to read
// - send_done timing depends on gsm_style
// - with gsm_style and clock output off the card clock is driven and held at the fixed level
// - parity error drives line low for 1 etu from 10.5 etu
// - card nack makes the same byte resend after at least 2 etu
// - card clock runs at 372 times the bit rate
// - inversion touches only data bits, never parity
`timescale 1ns/1ps
`default_nettype none
`include "scsc_cfg.svh"
module scsc_top
  import scsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_in_pin_i,
  output logic line_out_pin_o,
  output logic line_out_pin_oe_o,
  output logic card_clk_pin_o,
  output logic card_clk_pin_oe_o,
  output logic send_irq_o,
  output logic rcv_irq_o,
  output logic fault_irq_o
);
  logic [7:0] frame_q, frame_d, rate_q, rate_d, ctrl_q, ctrl_d, sbuf_q, sbuf_d;
  logic [7:0] flags_q, flags_d, rbuf_q, rbuf_d, mode_q, mode_d, seen_q, seen_d;
  logic [7:0] rval;
  logic [31:0] rdat_q, rdat_d;
  logic ack_q, ack_d, acc, wr, rd, line_s;
  logic [2:0] idx;
  scsc_tx_state_type tx_st_q, tx_st_d;
  scsc_rx_state_type rx_st_q, rx_st_d;
  logic [7:0] tx_sub_q, tx_sub_d, rx_sub_q, rx_sub_d, tx_enc, rx_byte;
  logic [4:0] tx_h_q, tx_h_d, rx_h_q, rx_h_d;
  logic [9:0] rx_sh_q, rx_sh_d, tx_bits;
  logic rx_prev_q, rx_prev_d, rx_bad_q, rx_bad_d, tx_step, rx_step;
  logic tx_start, ev_done, ev_nack, ev_par, ev_ovr, ev_rfull, ev_load;
  logic send_on, rcv_on, card_on, gsm, tx_low, rx_low;
  logic drv_q, drv_d, ck_q, ck_d, ckoe_q, ckoe_d, sirq_q, sirq_d;
  logic rirq_q, rirq_d, firq_q, firq_d;

  // bit order and data inversion of one byte; parity stays untouched
  function automatic logic [7:0] scsc_codec(input logic [7:0] b, input logic msb,
                                            input logic inv);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = msb ? b[7 - i] : b[i];
    return inv ? ~r : r;
  endfunction

  // rate generator and line synchroniser
  scsc_rate_if rate_bus();
  assign rate_bus.ce = ce_i;
  assign rate_bus.psel = frame_q[`SCSC_FC_PS];
  assign rate_bus.div = rate_q;

  scsc_rate_gen u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rate(rate_bus)
  );

  scsc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(line_in_pin_i),
    .q_o(line_s)
  );

  // wishbone decode and mode bits
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign idx = wb_adr_i[4:2];
  assign card_on = mode_q[`SCSC_MD_ON];
  assign gsm = frame_q[`SCSC_FC_GSM];
  assign send_on = card_on & ctrl_q[`SCSC_SC_SEND];
  assign rcv_on = card_on & ctrl_q[`SCSC_SC_RCV];

  // register file, flags and read mux
  always_comb
  begin
    frame_d = frame_q;
    rate_d = rate_q;
    ctrl_d = ctrl_q;
    sbuf_d = sbuf_q;
    flags_d = flags_q;
    rbuf_d = rbuf_q;
    mode_d = mode_q;
    seen_d = seen_q;
    ack_d = acc;
    rdat_d = rdat_q;
    if (wr)
    begin
      case (idx)
        `SCSC_IDX_FRAME: frame_d = wb_dat_i[7:0];
        `SCSC_IDX_RATE: rate_d = wb_dat_i[7:0];
        `SCSC_IDX_CTRL: ctrl_d = wb_dat_i[7:0];
        `SCSC_IDX_SBUF: sbuf_d = wb_dat_i[7:0];
        `SCSC_IDX_MODE: mode_d = wb_dat_i[7:0] & `SCSC_MODE_MASK;
        `SCSC_IDX_FLAGS:
        begin
          flags_d = flags_q & (wb_dat_i[7:0] | ~seen_q);
          seen_d = seen_q & wb_dat_i[7:0];
        end
        default: ;
      endcase
    end
    // a send_buf write frees the byte as a DMA transfer would
    if (wr && idx == `SCSC_IDX_SBUF)
    begin
      flags_d[`SCSC_FL_SBE] = 1'b0;
      flags_d[`SCSC_FL_DONE] = 1'b0;
    end
    if (rd && idx == `SCSC_IDX_FLAGS)
      seen_d = seen_q | flags_q;
    // hardware events; sets come last so they win over clears
    if (tx_start)
      flags_d[`SCSC_FL_DONE] = 1'b0;
    if (ev_done)
    begin
      flags_d[`SCSC_FL_DONE] = 1'b1;
      flags_d[`SCSC_FL_SBE] = 1'b1;
    end
    if (ev_nack)
      flags_d[`SCSC_FL_NACK] = 1'b1;
    if (ev_par)
      flags_d[`SCSC_FL_PAR] = 1'b1;
    if (ev_ovr)
      flags_d[`SCSC_FL_OVR] = 1'b1;
    if (ev_rfull)
      flags_d[`SCSC_FL_RBF] = 1'b1;
    if (ev_load)
      rbuf_d = rx_byte;
    case (idx)
      `SCSC_IDX_FRAME: rval = frame_q;
      `SCSC_IDX_RATE: rval = rate_q;
      `SCSC_IDX_CTRL: rval = ctrl_q;
      `SCSC_IDX_SBUF: rval = sbuf_q;
      `SCSC_IDX_FLAGS: rval = flags_q & `SCSC_FLAGS_MASK;
      `SCSC_IDX_RBUF: rval = rbuf_q;
      `SCSC_IDX_MODE: rval = mode_q;
      default: rval = 8'h00;
    endcase
    if (rd)
      rdat_d = {24'h000000, rval};
  end

  // transmitter: frame, nack sample, retransmit gap
  always_comb
  begin
    tx_st_d = tx_st_q;
    tx_sub_d = tx_sub_q;
    tx_h_d = tx_h_q;
    tx_start = 1'b0;
    ev_done = 1'b0;
    ev_nack = 1'b0;
    tx_step = 1'b0;
    tx_enc = scsc_codec(sbuf_q, mode_q[`SCSC_MD_MSB], mode_q[`SCSC_MD_INV]);
    tx_bits = {^tx_enc ^ frame_q[`SCSC_FC_ODD], tx_enc, 1'b0};
    if (rate_bus.base_tick)
    begin
      if (tx_sub_q == `SCSC_HALF_LAST)
      begin
        tx_sub_d = 8'h00;
        tx_step = 1'b1;
      end
      else
      begin
        tx_sub_d = tx_sub_q + 8'h01;
      end
    end
    if (tx_step)
      tx_h_d = tx_h_q + 5'd1;
    case (tx_st_q)
      SCSC_TX_IDLE:
      begin
        tx_sub_d = 8'h00;
        tx_h_d = 5'd0;
        // start only on a base tick so the first half etu is as long as the rest
        if (send_on && !flags_q[`SCSC_FL_SBE] && rate_bus.base_tick)
        begin
          tx_st_d = SCSC_TX_FRAME;
          tx_start = 1'b1;
        end
      end
      SCSC_TX_FRAME:
      begin
        if (tx_step && tx_h_d == `SCSC_H_NACK && !line_s)
        begin
          ev_nack = 1'b1;
          tx_st_d = SCSC_TX_GAP;
        end
        else if (tx_step && tx_h_d == (gsm ? `SCSC_H_DONE_GSM : `SCSC_H_DONE))
        begin
          ev_done = 1'b1;
          tx_st_d = SCSC_TX_IDLE;
        end
      end
      SCSC_TX_GAP:
      begin
        if (tx_step && tx_h_d == `SCSC_H_RESEND)
        begin
          tx_st_d = SCSC_TX_FRAME;
          tx_h_d = 5'd0;
        end
      end
      default: tx_st_d = SCSC_TX_IDLE;
    endcase
    if (!send_on)
      tx_st_d = SCSC_TX_IDLE;
  end
  assign tx_low = (tx_st_q == SCSC_TX_FRAME) && (tx_h_q < `SCSC_H_PAR_END)
                  && !tx_bits[tx_h_q[4:1]];

  // receiver: mid-bit samples, parity check, error signal
  always_comb
  begin
    rx_st_d = rx_st_q;
    rx_sub_d = rx_sub_q;
    rx_h_d = rx_h_q;
    rx_sh_d = rx_sh_q;
    rx_bad_d = rx_bad_q;
    rx_prev_d = line_s;
    rx_step = 1'b0;
    ev_par = 1'b0;
    ev_ovr = 1'b0;
    ev_rfull = 1'b0;
    ev_load = 1'b0;
    rx_byte = scsc_codec(rx_sh_q[8:1], mode_q[`SCSC_MD_MSB], mode_q[`SCSC_MD_INV]);
    if (rate_bus.base_tick)
    begin
      if (rx_sub_q == `SCSC_HALF_LAST)
      begin
        rx_sub_d = 8'h00;
        rx_step = 1'b1;
      end
      else
      begin
        rx_sub_d = rx_sub_q + 8'h01;
      end
    end
    if (rx_step)
      rx_h_d = rx_h_q + 5'd1;
    case (rx_st_q)
      SCSC_RX_IDLE:
      begin
        rx_sub_d = 8'h00;
        rx_h_d = 5'd0;
        rx_bad_d = 1'b0;
        if (rcv_on && rx_prev_q && !line_s)
          rx_st_d = SCSC_RX_FRAME;
      end
      SCSC_RX_FRAME:
      begin
        if (rx_step && rx_h_d[0] && rx_h_d <= `SCSC_H_PAR)
          rx_sh_d = {line_s, rx_sh_q[9:1]};
        if (rx_step && rx_h_d == 5'd1 && line_s)
          rx_st_d = SCSC_RX_IDLE; // glitch, not a start bit
        if (rx_step && rx_h_d == `SCSC_H_PAR_END)
        begin
          if (^rx_sh_q[9:1] ^ frame_q[`SCSC_FC_ODD])
          begin
            rx_bad_d = 1'b1;
            ev_par = 1'b1;
            ev_load = 1'b1;
          end
          else if (flags_q[`SCSC_FL_RBF])
          begin
            ev_ovr = 1'b1;
          end
          else
          begin
            ev_load = 1'b1;
            ev_rfull = 1'b1;
          end
        end
        if (rx_step && rx_h_d == `SCSC_H_ERR_OFF)
          rx_st_d = SCSC_RX_IDLE;
      end
      default: rx_st_d = SCSC_RX_IDLE;
    endcase
    if (!rcv_on)
      rx_st_d = SCSC_RX_IDLE;
  end
  assign rx_low = (rx_st_q == SCSC_RX_FRAME) && rx_bad_q
                  && (rx_h_q >= `SCSC_H_ERR_ON) && (rx_h_q < `SCSC_H_ERR_OFF);

  // pins and interrupt request levels
  always_comb
  begin
    drv_d = card_on & (tx_low | rx_low);
    ck_d = ck_q;
    if (rate_bus.half_tick && (ctrl_q[`SCSC_SC_CKO] || (gsm && ck_q != ctrl_q[`SCSC_SC_FIX])))
      ck_d = ~ck_q;
    ckoe_d = card_on & (ctrl_q[`SCSC_SC_CKO] | gsm);
    sirq_d = flags_q[`SCSC_FL_DONE] & ctrl_q[`SCSC_SC_SIRQ];
    rirq_d = flags_q[`SCSC_FL_RBF] & ctrl_q[`SCSC_SC_RIRQ];
    firq_d = (flags_q[`SCSC_FL_OVR] | flags_q[`SCSC_FL_PAR] | flags_q[`SCSC_FL_NACK])
             & ctrl_q[`SCSC_SC_RIRQ];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_q <= `SCSC_RST_FRAME;
      rate_q <= `SCSC_RST_RATE;
      ctrl_q <= `SCSC_RST_CTRL;
      sbuf_q <= 8'h00;
      flags_q <= `SCSC_RST_FLAGS;
      rbuf_q <= 8'h00;
      mode_q <= `SCSC_RST_MODE;
      seen_q <= 8'h00;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      tx_st_q <= SCSC_TX_IDLE;
      tx_sub_q <= 8'h00;
      tx_h_q <= 5'd0;
      rx_st_q <= SCSC_RX_IDLE;
      rx_sub_q <= 8'h00;
      rx_h_q <= 5'd0;
      rx_sh_q <= 10'h3ff;
      rx_bad_q <= 1'b0;
      rx_prev_q <= 1'b1;
      drv_q <= 1'b0;
      ck_q <= 1'b0;
      ckoe_q <= 1'b0;
      sirq_q <= 1'b0;
      rirq_q <= 1'b0;
      firq_q <= 1'b0;
    end
    else if (ce_i)
    begin
      frame_q <= frame_d;
      rate_q <= rate_d;
      ctrl_q <= ctrl_d;
      sbuf_q <= sbuf_d;
      flags_q <= flags_d;
      rbuf_q <= rbuf_d;
      mode_q <= mode_d;
      seen_q <= seen_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      tx_st_q <= tx_st_d;
      tx_sub_q <= tx_sub_d;
      tx_h_q <= tx_h_d;
      rx_st_q <= rx_st_d;
      rx_sub_q <= rx_sub_d;
      rx_h_q <= rx_h_d;
      rx_sh_q <= rx_sh_d;
      rx_bad_q <= rx_bad_d;
      rx_prev_q <= rx_prev_d;
      drv_q <= drv_d;
      ck_q <= ck_d;
      ckoe_q <= ckoe_d;
      sirq_q <= sirq_d;
      rirq_q <= rirq_d;
      firq_q <= firq_d;
    end
  end

  // outputs straight from flip-flops except line_out_pin_o, tied low; data line is open drain, driven low only
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign line_out_pin_o = 1'b0;
  assign line_out_pin_oe_o = drv_q;
  assign card_clk_pin_o = ck_q;
  assign card_clk_pin_oe_o = ckoe_q;
  assign send_irq_o = sirq_q;
  assign rcv_irq_o = rirq_q;
  assign fault_irq_o = firq_q;
endmodule
`default_nettype wire

// ### sim/scsc_card.sv
/*
  Behavioural card on the shared open-drain data line.
  Assumes the bench resolves the line with a pull-up, 744 clocks per etu.
*/
`timescale 1ns/1ps
`default_nettype none
module scsc_card (
  input wire logic clk_i,
  input wire logic line_i,
  output logic drive_o
);
  localparam int ETU = 744;
  logic busy = 1'b0;
  logic [7:0] rx_q;
  logic par_q;
  logic err_q;
  logic [8:0] d;
  int nack_cnt = 0, frames = 0, last_gap = 0, t_now = 0, t_start = 0;
  initial drive_o = 1'b0;
  always @(posedge clk_i) t_now <= t_now + 1;
  // take a frame, sample mid-bit, send the error signal on request
  always @(negedge line_i)
    if (!busy)
    begin
      last_gap = t_now - t_start;
      t_start = t_now;
      repeat (ETU + ETU / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++)
      begin
        d[i] = line_i;
        repeat (ETU) @(posedge clk_i);
      end
      rx_q = d[7:0];
      par_q = !(^d);
      frames++;
      if (nack_cnt > 0)
      begin
        nack_cnt--;
        drive_o <= 1'b1;
        repeat (ETU) @(posedge clk_i);
        drive_o <= 1'b0;
      end
    end
  // send one frame, then look for the error signal at 11 etu
  task automatic send(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f = {^b ^ bad, b, 1'b0};
    busy = 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      drive_o <= !f[i];
      repeat (ETU) @(posedge clk_i);
    end
    drive_o <= 1'b0;
    repeat (ETU) @(posedge clk_i);
    err_q = !line_i;
    repeat (3 * ETU) @(posedge clk_i);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/scsc_top_sva.sv
/*
  Port checker of the smart card serial channel top, bound to it.
  Assumes one clock and 744 clocks per etu while frames run.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scsc_cfg.svh"
module scsc_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic line_in_pin_i,
  input wire logic line_out_pin_o,
  input wire logic line_out_pin_oe_o,
  input wire logic card_clk_pin_o,
  input wire logic card_clk_pin_oe_o,
  input wire logic send_irq_o,
  input wire logic rcv_irq_o,
  input wire logic fault_irq_o
);
  localparam int ETU = 744;
  localparam int MAX_LOW = 7440;
  int run_q;
  int run_d;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // length of the current stretch with the line pulled low
  always_comb run_d = line_out_pin_oe_o ? run_q + 1 : 0;
  always_ff @(posedge clk_i) run_q <= rst_i ? 0 : run_d;
  // bus answers one cycle after taking, for one cycle only
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i[4:2] == 3'h7 |=> wb_dat_o == 32'h0)
    else $error("unmapped slot not zero");
  rst_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !line_out_pin_oe_o && !card_clk_pin_oe_o && !send_irq_o)
    else $error("outputs active after reset");
  // line low stretches last whole etus, at most a full frame
  oe_etu_a: assert property ($fell(line_out_pin_oe_o) |-> run_q % ETU == 0)
    else $error("line low stretch not whole etus");
  oe_max_a: assert property (run_q <= MAX_LOW)
    else $error("line held low too long");
  send_clear_a: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i[4:2] == `SCSC_IDX_SBUF |=> ##1 !send_irq_o)
    else $error("send irq kept after buffer write");
endmodule
bind scsc_top scsc_top_sva chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_in_pin_i, .line_out_pin_o,
  .line_out_pin_oe_o, .card_clk_pin_o, .card_clk_pin_oe_o, .send_irq_o, .rcv_irq_o,
  .fault_irq_o);
`default_nettype wire

// ### sim/scsc_top_tb.sv
/*
  Self-checking bench of the smart card serial channel.
  Assumes the card model scsc_card and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module scsc_top_tb;
  localparam int ETU = 744;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_q = 1'b0, stb_q = 1'b0, we_q = 1'b0;
  logic [4:0] adr_q = 5'h00;
  logic [3:0] sel_q = 4'h0;
  logic [31:0] dat_q = 32'h0, wb_dat_o, q;
  logic wb_ack_o, line_out_pin_o, line_out_pin_oe_o, card_clk_pin_o, card_clk_pin_oe_o;
  logic send_irq_o, rcv_irq_o, fault_irq_o, card_drive;
  logic [7:0] rv [8] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h84, 8'h00, 8'h00, 8'h00};
  int ps [3] = '{0, 0, 1};
  int dv [3] = '{0, 1, 0};
  int error_cnt = 0, comparisons = 0, n1, n2, f0;
  wire logic line;
  // open-drain line with pull-up
  assign line = !((line_out_pin_oe_o && !line_out_pin_o) || card_drive);
  always #10 clk_i = !clk_i;
  scsc_top dut (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc_q), .wb_stb_i(stb_q),
    .wb_we_i(we_q), .wb_adr_i(adr_q), .wb_sel_i(sel_q), .wb_dat_i(dat_q), .wb_dat_o,
    .wb_ack_o, .line_in_pin_i(line), .line_out_pin_o, .line_out_pin_oe_o, .card_clk_pin_o,
    .card_clk_pin_oe_o, .send_irq_o, .rcv_irq_o, .fault_irq_o);
  scsc_card card (.clk_i, .line_i(line), .drive_o(card_drive));
  task automatic finish_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic limit(input int n, input int m);
    if (n >= m)
    begin
      error_cnt++;
      finish_test;
    end
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_q <= 1'b1;
    stb_q <= 1'b1;
    we_q <= w;
    adr_q <= a;
    sel_q <= s;
    dat_q <= {24'h0, d};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && ++n < 20);
    q = wb_dat_o;
    cyc_q <= 1'b0;
    stb_q <= 1'b0;
    limit(n, 20);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd_chk(input string name, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hf);
    check(name, q, {24'h0, e});
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // clocks from the last frame's first line fall until the send irq is seen
  task automatic wait_done(output int n);
    n = 0;
    do
      @(posedge clk_i);
    while (send_irq_o !== 1'b1 && ++n < 20000);
    limit(n, 20000);
    n = card.t_now - card.t_start;
  endtask
  // rising card clock edges within one etu of system clocks
  task automatic count_clk(output int n);
    logic p;
    n = 0;
    p = card_clk_pin_o;
    repeat (ETU)
    begin
      @(posedge clk_i);
      n += int'(card_clk_pin_o === 1'b1 && p === 1'b0);
      p = card_clk_pin_o;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped slot included
    for (int i = 0; i < 8; i++)
      if (i != 3)
        rd_chk("reset value", 5'(4 * i), rv[i]);
    bus(1'b1, 5'h00, 8'h80, 4'h0);
    rd_chk("frame with sel low", 5'h00, 8'h00);
    wr(5'h08, 8'h00);
    wr(5'h18, 8'h01);
    idle(2);
    check("line oe idle", {line_out_pin_oe_o, line_out_pin_o}, 2'b00);
    check("clock oe off", card_clk_pin_oe_o, 1'b0);
    wr(5'h08, 8'h01);
    idle(2);
    check("clock oe on", card_clk_pin_oe_o, 1'b1);
    // card clock rate over prescaler and divisor settings
    for (int i = 0; i < 3; i++)
    begin
      wr(5'h00, 8'(ps[i]));
      wr(5'h04, 8'(dv[i]));
      idle(16);
      count_clk(n1);
      check("card clock rises", n1, 372 / ((1 << 2 * ps[i]) * (dv[i] + 1)));
    end
    wr(5'h00, 8'h00);
    idle(ETU);
    wr(5'h08, 8'ha1);
    idle(2);
    check("send irq idle", send_irq_o, 1'b1);
    wr(5'h0c, 8'h3b);
    wait_done(n1);
    check("card byte", card.rx_q, 8'h3b);
    check("card parity", card.par_q, 1'b1);
    rd_chk("flags after send", 5'h10, 8'h84);
    // card refuses the first frame
    f0 = card.frames;
    card.nack_cnt = 1;
    wr(5'h0c, 8'ha5);
    wait_done(n2);
    check("frames sent", card.frames - f0, 2);
    check("resend spacing", card.last_gap, 27 * 372);
    check("resent byte", card.rx_q, 8'ha5);
    check("fault irq masked", fault_irq_o, 1'b0);
    rd_chk("flags after nack", 5'h10, 8'h94);
    wr(5'h10, 8'hef);
    rd_chk("nack cleared", 5'h10, 8'h84);
    wr(5'h00, 8'h80);
    wr(5'h0c, 8'hc3);
    wait_done(n2);
    check("done moment", n1 - n2, 3 * 372);
    // inverse convention: msb first, data inverted, parity over line bits
    wr(5'h18, 8'h0d);
    wr(5'h00, 8'h90);
    wr(5'h0c, 8'h3f);
    wait_done(n2);
    check("inverse byte", card.rx_q, 8'h03);
    check("inverse parity", card.par_q, 1'b0);
    wr(5'h18, 8'h01);
    // clock held at each fixed level
    for (int l = 0; l < 2; l++)
    begin
      wr(5'h08, {6'h00, 1'(l), 1'b0});
      idle(8);
      check("fixed clock", {card_clk_pin_oe_o, card_clk_pin_o}, {1'b1, 1'(l)});
    end
    wr(5'h00, 8'h00);
    wr(5'h08, 8'h01);
    idle(ETU);
    wr(5'h08, 8'h51);
    card.send(8'h5a, 1'b0);
    check("rcv irq", rcv_irq_o, 1'b1);
    check("no error signal", card.err_q, 1'b0);
    rd_chk("good byte", 5'h14, 8'h5a);
    card.send(8'h33, 1'b1);
    check("error signal", card.err_q, 1'b1);
    check("fault irq", fault_irq_o, 1'b1);
    rd_chk("bad byte kept", 5'h14, 8'h33);
    rd_chk("parity flags", 5'h10, 8'hcc);
    card.send(8'h77, 1'b0);
    rd_chk("overrun flags", 5'h10, 8'hec);
    wr(5'h14, 8'h00);
    rd_chk("buffer held", 5'h14, 8'h33);
    wr(5'h10, 8'h84);
    rd_chk("flags cleared", 5'h10, 8'h84);
    idle(2);
    check("irqs low", {rcv_irq_o, fault_irq_o}, 2'b00);
    finish_test;
  end
endmodule
`default_nettype wire
